// ===== hw/opmode_consts.vh
// Constants for the operating mode and system control register block
`ifndef OPMODE_CONSTS_VH
`define OPMODE_CONSTS_VH
`define ADDR_MODE_PIN_STATUS 16'hfff1
`define ADDR_SYSTEM_CONTROL  16'hfff2
`define ADDR_BUS_STATUS      16'hfff8
`define SYSCTL_RESET         8'h0b
`define SYSCTL_WMASK         8'hfd
`define SYSCTL_FIXED_ONES    8'h02
`define MDS_FIXED_ONES       8'hc0
`define BIT_STANDBY          7
`define BIT_UE               3
`define BIT_NMI_EDGE_SELECT            2
`define BIT_ONCHIP_RAM_ENABLE             0
`define MODE_CODE_1          3'h1
`define MODE_CODE_2          3'h2
`define MODE_CODE_3          3'h3
`define MODE_CODE_4          3'h4
`define WAIT_8K              18'h02000
`define WAIT_16K             18'h04000
`define WAIT_32K             18'h08000
`define WAIT_64K             18'h10000
`define WAIT_128K            18'h20000
`define SETTLE_MIN_MS        8
`endif

// ===== hw/settle_timer.v
// Oscillator settling wait counter used after leaving software standby
`timescale 1ns/10ps
`include "opmode_consts.vh"
module settle_timer (
   // Clock and reset
   input  wire        core_clk,
   input  wire        resetn,
   // Control
   input  wire        start,
   input  wire [2:0]  sel,
   // Status
   output reg         busy_r,
   output reg         illegal_r
);
   reg [17:0] cnt_r;
   reg [17:0] load_val;

   // Settling length per select code
   always @* begin
      case (sel)
         3'h0:    load_val = `WAIT_8K;
         3'h1:    load_val = `WAIT_16K;
         3'h2:    load_val = `WAIT_32K;
         3'h3:    load_val = `WAIT_64K;
         3'h4:    load_val = `WAIT_128K;
         3'h5:    load_val = `WAIT_128K;
         default: load_val = `WAIT_128K;
      endcase
   end

   always @(posedge core_clk) begin
      if (!resetn) begin
         cnt_r     <= 18'h00000;
         busy_r    <= 1'b0;
         illegal_r <= 1'b0;
      end else if (start && !busy_r) begin
         cnt_r     <= load_val - 18'h00001;
         busy_r    <= 1'b1;
         illegal_r <= sel[2] & sel[1];
      end else if (busy_r) begin
         if (cnt_r == 18'h00000) begin
            busy_r <= 1'b0;
         end else begin
            cnt_r <= cnt_r - 18'h00001;
         end
      end
   end
endmodule // settle_timer

// ===== hw/opmode_sysctl.v
// Operating mode decode and system control registers on a Wishbone slave
// Summary of operation
// - Mode pins 001/010 give 1 Mbyte, 011/100 give 16 Mbyte; odd modes start 8-bit.
// - Data bus is 8 bits if all areas 8-bit, else 16 bits.
// - RAM enabled in all modes; with enable clear RAM accesses go external.
// - Read-only mode pin status register at fff1, value from pins.
// - Mode status bits 7,6 read 1, bits 5 to 3 read 0.
// - Mode status bits 2 to 0 show pin levels sampled at read.
// - System control register at fff2, resets to 0b.
// - Bit 7 chooses sleep (0) or software standby (1) on sleep.
// - Standby bit stays set after interrupt exit; only a write or reset clears it.
// - Bits 6 to 4 select settle wait 8192 to 131072 states; 11x illegal.
// - After interrupt exit from standby, hold CPU for selected wait.
// - Bit 3 clear makes user bit an interrupt mask; reset value 1.
// - Bit 2 selects NMI edge: 0 falling, 1 rising; reset 0.
// - Bit 1 reserved, reads 1, ignores writes.
// - RAM enable bit 0 reset to 1, kept through software standby.
// - Exception entry sets mask only if user bit enable is 1, else both.
// - 8-bit start modes switch to 16-bit once any area is 16-bit.
`timescale 1ns/10ps
`include "opmode_consts.vh"
module opmode_sysctl (
   // Clock and reset
   input  wire        core_clk,
   input  wire        resetn,
   // Wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [15:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Mode pins
   input  wire        mode_pin_2,
   input  wire        mode_pin_1,
   input  wire        mode_pin_0,
   // Bus controller area widths, one bit per area, 1 = 16-bit
   input  wire [7:0]  area_width_config,
   // CPU power and exception events
   input  wire        sleep_exec,
   input  wire        ext_irq_wake,
   input  wire        exc_entry,
   input  wire        nmi_in,
   input  wire        ram_addr_hit,
   // Mode and configuration outputs
   output reg  [2:0]  mode_num_r,
   output reg         space_16m_r,
   output reg         init_bus16_r,
   output reg         bus16_r,
   output reg         mode_invalid_r,
   output reg         onchip_ram_sel_r,
   output reg         ext_ram_route_r,
   // Power state outputs
   output reg         sleep_mode_r,
   output reg         sw_standby_r,
   output reg         cpu_hold_r,
   output reg         settle_illegal_r,
   // Exception and interrupt outputs
   output reg         set_int_mask_r,
   output reg         set_user_bit_r,
   output reg         nmi_req_r
);
   localparam ST_RUN    = 2'h0;
   localparam ST_SLEEP  = 2'h1;
   localparam ST_STBY   = 2'h2;
   localparam ST_SETTLE = 2'h3;

   reg  [7:0] sysctl_r;
   reg  [1:0] pst_r;
   reg        reset_seen_r;
   reg        nmi_d_r;
   reg        tmr_start_r;
   wire [2:0] mode_pins;
   wire       tmr_busy;
   wire       tmr_illegal;
   wire       wb_req;
   wire       wr_ctl;
   wire       any16;
   wire       nmi_edge;
   reg  [7:0] rd_byte;

   assign mode_pins = {mode_pin_2, mode_pin_1, mode_pin_0};
   assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_ctl    = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `ADDR_SYSTEM_CONTROL);
   assign any16     = |area_width_config;
   assign nmi_edge  = sysctl_r[`BIT_NMI_EDGE_SELECT] ? (nmi_in & ~nmi_d_r) : (~nmi_in & nmi_d_r);

   // Read data mux
   always @* begin
      case (wb_adr_i)
         `ADDR_MODE_PIN_STATUS: rd_byte = `MDS_FIXED_ONES | {5'h00, mode_pins};
         `ADDR_SYSTEM_CONTROL:  rd_byte = sysctl_r | `SYSCTL_FIXED_ONES;
         `ADDR_BUS_STATUS:      rd_byte = {5'h00, bus16_r, space_16m_r, sw_standby_r};
         default:               rd_byte = 8'h00;
      endcase
   end

   // Wishbone slave, one wait state, unmapped reads return zero
   always @(posedge core_clk) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            wb_dat_o <= {24'h000000, rd_byte};
         end
      end
   end

   // System control register
   always @(posedge core_clk) begin
      if (!resetn) begin
         sysctl_r <= `SYSCTL_RESET;
      end else if (wr_ctl) begin
         sysctl_r <= (wb_dat_i[7:0] & `SYSCTL_WMASK) | `SYSCTL_FIXED_ONES;
      end
   end

   // Mode decode latched once after reset release
   always @(posedge core_clk) begin
      if (!resetn) begin
         reset_seen_r   <= 1'b0;
         mode_num_r     <= 3'h0;
         space_16m_r    <= 1'b0;
         init_bus16_r   <= 1'b0;
         mode_invalid_r <= 1'b0;
      end else if (!reset_seen_r) begin
         reset_seen_r <= 1'b1;
         case (mode_pins)
            `MODE_CODE_1: begin
               mode_num_r <= 3'h1; space_16m_r <= 1'b0; init_bus16_r <= 1'b0;
            end
            `MODE_CODE_2: begin
               mode_num_r <= 3'h2; space_16m_r <= 1'b0; init_bus16_r <= 1'b1;
            end
            `MODE_CODE_3: begin
               mode_num_r <= 3'h3; space_16m_r <= 1'b1; init_bus16_r <= 1'b0;
            end
            `MODE_CODE_4: begin
               mode_num_r <= 3'h4; space_16m_r <= 1'b1; init_bus16_r <= 1'b1;
            end
            default: begin
               mode_invalid_r <= 1'b1;
            end
         endcase
      end
   end

   // Bus width and RAM routing
   always @(posedge core_clk) begin
      if (!resetn) begin
         bus16_r          <= 1'b0;
         onchip_ram_sel_r <= 1'b0;
         ext_ram_route_r  <= 1'b0;
      end else begin
         bus16_r          <= reset_seen_r ? any16 : init_bus16_r;
         onchip_ram_sel_r <= ram_addr_hit & sysctl_r[`BIT_ONCHIP_RAM_ENABLE];
         ext_ram_route_r  <= ram_addr_hit & ~sysctl_r[`BIT_ONCHIP_RAM_ENABLE];
      end
   end

   // Power state sequence
   always @(posedge core_clk) begin
      if (!resetn) begin
         pst_r        <= ST_RUN;
         sleep_mode_r <= 1'b0;
         sw_standby_r <= 1'b0;
         cpu_hold_r   <= 1'b0;
         tmr_start_r  <= 1'b0;
      end else begin
         tmr_start_r <= 1'b0;
         case (pst_r)
            ST_RUN: begin
               if (sleep_exec) begin
                  if (sysctl_r[`BIT_STANDBY]) begin
                     pst_r <= ST_STBY;
                     sw_standby_r <= 1'b1;
                     cpu_hold_r <= 1'b1;
                  end else begin
                     pst_r <= ST_SLEEP;
                     sleep_mode_r <= 1'b1;
                  end
               end
            end
            ST_SLEEP: begin
               if (ext_irq_wake) begin
                  pst_r <= ST_RUN;
                  sleep_mode_r <= 1'b0;
               end
            end
            ST_STBY: begin
               if (ext_irq_wake) begin
                  pst_r <= ST_SETTLE;
                  sw_standby_r <= 1'b0;
                  tmr_start_r <= 1'b1;
               end
            end
            ST_SETTLE: begin
               if (!tmr_start_r && !tmr_busy) begin
                  pst_r <= ST_RUN;
                  cpu_hold_r <= 1'b0;
               end
            end
            default: begin
               pst_r <= ST_RUN;
            end
         endcase
      end
   end

   // Exception entry and NMI edge detection
   always @(posedge core_clk) begin
      if (!resetn) begin
         set_int_mask_r   <= 1'b0;
         set_user_bit_r   <= 1'b0;
         nmi_req_r        <= 1'b0;
         nmi_d_r          <= 1'b0;
         settle_illegal_r <= 1'b0;
      end else begin
         set_int_mask_r   <= exc_entry;
         set_user_bit_r   <= exc_entry & ~sysctl_r[`BIT_UE];
         nmi_d_r          <= nmi_in;
         nmi_req_r        <= nmi_edge;
         settle_illegal_r <= tmr_illegal;
      end
   end

   settle_timer u_settle (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .start     (tmr_start_r),
      .sel       (sysctl_r[6:4]),
      .busy_r    (tmr_busy),
      .illegal_r (tmr_illegal)
   );
endmodule // opmode_sysctl

// ===== tb/mode_strap.sv
// Board strap model that holds the three mode pins
`timescale 1ns/10ps
module mode_strap (
   // Strap code
   input  wire [2:0] code,
   // Mode pins
   output wire       mode_pin_2,
   output wire       mode_pin_1,
   output wire       mode_pin_0
);
   // Only codes 1 to 4, changed only while reset is held
   assign {mode_pin_2, mode_pin_1, mode_pin_0} = code;
endmodule // mode_strap

// ===== tb/opmode_sysctl_assertions.sv
// Concurrent checks for the operating mode and system control block
`timescale 1ns/10ps
module opmode_sysctl_assertions (
   // Clock, reset and bus
   input wire        core_clk,
   input wire        resetn,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [15:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   // Pins and events
   input wire        mode_pin_2,
   input wire        mode_pin_1,
   input wire        mode_pin_0,
   input wire [7:0]  area_width_config,
   input wire        exc_entry,
   input wire        nmi_in,
   // Outputs
   input wire [2:0]  mode_num_r,
   input wire        space_16m_r,
   input wire        init_bus16_r,
   input wire        bus16_r,
   input wire        sw_standby_r,
   input wire        cpu_hold_r,
   input wire        set_int_mask_r,
   input wire        nmi_req_r
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   chk_ack_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   chk_status_bits: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == 16'hfff1 |->
      wb_dat_o == {24'h0, 5'h18, mode_pin_2, mode_pin_1, mode_pin_0})
      else $error("bad mode status");
   chk_mode_decode: assert property (mode_num_r != 3'h0 |->
      mode_num_r == {mode_pin_2, mode_pin_1, mode_pin_0} && space_16m_r == (mode_num_r > 3'h2)
      && init_bus16_r == !mode_num_r[0])
      else $error("bad decode");
   chk_mode_held: assert property ($past(resetn) && $past(resetn, 2) |->
      $stable(mode_num_r) && $stable(space_16m_r) && $stable(init_bus16_r))
      else $error("mode moved");
   chk_bus_width: assert property (
      $past(resetn) && $past(resetn, 2) && $stable(area_width_config) |->
      bus16_r == (|area_width_config))
      else $error("bad width");
   chk_nmi_edge: assert property (nmi_req_r |->
      $past(nmi_in) != $past(nmi_in, 2) || $past(nmi_in, 2) != $past(nmi_in, 3))
      else $error("nmi without edge");
   chk_exc_mask: assert property (exc_entry |=> set_int_mask_r)
      else $error("no mask set");
   chk_hold_wake: assert property ($past(resetn) && $fell(sw_standby_r) |->
      cpu_hold_r [*8])
      else $error("hold dropped");
   cover property (wb_ack_o && wb_we_i);
   cover property ($fell(sw_standby_r));
   cover property (nmi_req_r);
endmodule // opmode_sysctl_assertions

bind opmode_sysctl opmode_sysctl_assertions i_chk (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .mode_pin_2, .mode_pin_1, .mode_pin_0,
   .area_width_config, .exc_entry, .nmi_in, .mode_num_r, .space_16m_r, .init_bus16_r,
   .bus16_r, .sw_standby_r, .cpu_hold_r, .set_int_mask_r, .nmi_req_r);

// ===== tb/opmode_sysctl_tb.sv
// Self-checking bench for the operating mode and system control block
`timescale 1ns/10ps
module opmode_sysctl_tb;
   // Stimulus
   logic        core_clk = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic        sleep_exec = 0, ext_irq_wake = 0, exc_entry = 0, nmi_in = 0, ram_addr_hit = 1;
   logic [15:0] wb_adr_i = 16'h0;
   logic [31:0] wb_dat_i = 32'h0, q;
   logic [7:0]  area_width_config = 8'h0;
   logic [2:0]  code = 3'h1;
   // Observed
   logic        wb_ack_o, mode_pin_2, mode_pin_1, mode_pin_0, space_16m_r, init_bus16_r;
   logic        bus16_r, onchip_ram_sel_r, ext_ram_route_r, sleep_mode_r, sw_standby_r;
   logic        cpu_hold_r, set_int_mask_r, set_user_bit_r, nmi_req_r, seen;
   logic [31:0] wb_dat_o;
   logic [2:0]  mode_num_r;
   int          num_errors = 0, compares = 0, n;

   always #4 core_clk = ~core_clk;

   mode_strap i_mode_strap (.code, .mode_pin_2, .mode_pin_1, .mode_pin_0);
   opmode_sysctl i_opmode_sysctl (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i(4'h1), .wb_dat_i, .wb_dat_o, .wb_ack_o, .mode_pin_2, .mode_pin_1,
      .mode_pin_0, .area_width_config, .sleep_exec, .ext_irq_wake, .exc_entry, .nmi_in,
      .ram_addr_hit, .mode_num_r, .space_16m_r, .init_bus16_r, .bus16_r, .mode_invalid_r(),
      .onchip_ram_sel_r, .ext_ram_route_r, .sleep_mode_r, .sw_standby_r, .cpu_hold_r,
      .settle_illegal_r(), .set_int_mask_r, .set_user_bit_r, .nmi_req_r);

   task check(input logic [31:0] s, e, input string what);
      compares++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, s);
      end
   endtask

   task wb(input logic we, input logic [15:0] adr, input logic [7:0] dat);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h0, dat};
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      check(n < 20, 1, "ack");
      q = wb_dat_o;
      @(posedge core_clk);
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      @(posedge core_clk);
   endtask

   task pulse(input int which);
      if (which == 0) sleep_exec <= 1;
      else exc_entry <= 1;
      @(posedge core_clk);
      sleep_exec <= 0;
      exc_entry <= 0;
      repeat (2) @(posedge core_clk);
   endtask

   task nmi_op(input logic lvl);
      nmi_in <= lvl;
      seen = 0;
      repeat (3) begin
         @(negedge core_clk);
         seen |= nmi_req_r;
      end
      @(posedge core_clk);
   endtask

   task give_verdict;
      if (num_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #200000;
      num_errors++;
      give_verdict;
   end

   initial begin
      for (int m = 1; m <= 4; m++) begin
         resetn <= 0;
         code <= m[2:0];
         repeat (4) @(posedge core_clk);
         resetn <= 1;
         repeat (3) @(posedge core_clk);
         check(mode_num_r, m, "mode");
         check({space_16m_r, init_bus16_r}, {m > 2, ~m[0]}, "space width");
         wb(1, 16'hfff1, 8'h00);
         wb(0, 16'hfff1, 8'h00);
         check(q, {24'h0, 5'h18, m[2:0]}, "mode status");
      end
      wb(0, 16'hfff2, 8'h00);
      check(q, 32'h0b, "sysctl reset");
      wb(0, 16'h0000, 8'h00);
      check(q, 32'h0, "unmapped");
      pulse(1);
      check({set_int_mask_r, set_user_bit_r}, 2'b00, "entry gone");
      wb(1, 16'hfff2, 8'h04);
      wb(0, 16'hfff2, 8'h00);
      check(q, 32'h06, "sysctl write");
      check({onchip_ram_sel_r, ext_ram_route_r}, 2'b01, "ram route");
      exc_entry <= 1;
      @(posedge core_clk);
      exc_entry <= 0;
      @(negedge core_clk);
      check({set_int_mask_r, set_user_bit_r}, 2'b11, "entry ue0");
      @(posedge core_clk);
      nmi_op(1);
      check(seen, 1, "nmi rise");
      nmi_op(0);
      check(seen, 0, "nmi fall");
      area_width_config <= 8'h10;
      repeat (3) @(posedge core_clk);
      check(bus16_r, 1, "bus wide");
      area_width_config <= 8'h00;
      repeat (3) @(posedge core_clk);
      check(bus16_r, 0, "bus narrow");
      wb(1, 16'hfff2, 8'h81);
      pulse(0);
      check({sw_standby_r, cpu_hold_r}, 2'b11, "standby");
      ext_irq_wake <= 1;
      @(posedge core_clk);
      ext_irq_wake <= 0;
      n = 0;
      while (cpu_hold_r === 1'b1 && n < 9000) begin
         @(posedge core_clk);
         n++;
      end
      check(n >= 8192 && n <= 8200, 1, "settle span");
      check(sw_standby_r, 0, "woken");
      wb(0, 16'hfff2, 8'h00);
      check(q, 32'h83, "standby kept");
      wb(1, 16'hfff2, 8'h01);
      pulse(0);
      check({sleep_mode_r, sw_standby_r}, 2'b10, "sleep");
      give_verdict;
   end
endmodule // opmode_sysctl_tb
